// file: design/dpll_status_control_pins.v
`timescale 1ns/1ps
`include "dpllsc_defines.vh"
// Behaviour
// - lock output high while frequency locked to the selected reference.
// - holdover output high for as long as the loop is in holdover.
// - each reference has a failure output for out-of-range or abrupt changes.
// - test data out changes on falling test clock, released when not scanning.
// - test reset low forces test-logic-reset at once, no clock needed.
// - hitless select low keeps the stored corrector delay on return to normal.
// - hitless select high re-measures the corrector delay on return to normal.
// - operating mode decoded from both mode-select bits together.
// - after reset release, stay in reset for 3 ms with outputs released.
module dpll_status_control_pins #(
   parameter RESET_HOLD_CYC = `DPLLSC_RESET_HOLD_CYC,
   parameter DLY_W          = 16
) (
   input  wire             sys_clk,
   input  wire             rst_n,
   input  wire             clkEn,
   input  wire             op_mode_bit0,
   input  wire             op_mode_bit1,
   input  wire             hitless_phase_select,
   input  wire [1:0]       application_select,
   input  wire             freqLocked,
   input  wire             autoHoldover,
   input  wire [2:0]       refOutOfRange,
   input  wire [2:0]       refAbrupt,
   input  wire [DLY_W-1:0] measuredDelay,
   input  wire             testClk,
   input  wire             testModeSel,
   input  wire             testDataIn,
   input  wire             testRst_n,
   output reg              lockOut,
   output reg              lockOe_n,
   output reg              holdoverOut,
   output reg              holdoverOe_n,
   output reg              ref_a_failure,
   output reg              ref_b_failure,
   output reg              ref_c_failure,
   output reg              refFailOe_n,
   output reg  [1:0]       opMode,
   output reg  [DLY_W-1:0] phase_error_corrector,
   output reg              correctorLoad,
   output wire             testDataOut,
   output wire             testDataOe_n
);
   reg  [31:0]      holdCnt_r;
   reg              inReset_r;
   reg  [2:0]       tckSync_r;
   reg  [2:0]       tmsSync_r;
   reg  [2:0]       tdiSync_r;
   reg              tckLevel_r;
   reg              tmsLevel_r;
   reg              tdiLevel_r;
   reg  [1:0]       prevMode_r;
   reg              prevHold_r;
   wire [1:0]       modeSel;
   wire             modeHold;
   wire             modeFree;
   wire             holdNow;
   wire             returning;
   wire [2:0]       refFail;
   wire             tckRise;
   wire             tckFall;
   wire             tapRstAsync;
   wire             tdoRaw;
   wire             tdoOeRaw;
   // ----------------------------------------
   // mode decode
   // ----------------------------------------
   assign modeSel  = {op_mode_bit1, op_mode_bit0};
   assign modeHold = (modeSel == `DPLLSC_MODE_HOLDOVER) ||
                     ((modeSel == `DPLLSC_MODE_AUTO) && autoHoldover);
   assign modeFree = (modeSel == `DPLLSC_MODE_FREERUN);
   assign holdNow  = modeHold && !modeFree;
   assign returning = !holdNow && !modeFree && (prevHold_r ||
                      (prevMode_r == `DPLLSC_MODE_FREERUN));
   // ----------------------------------------
   // reference failure
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : gFail
         assign refFail[gi] = refOutOfRange[gi] || refAbrupt[gi];
      end
   endgenerate
   // ----------------------------------------
   // reset hold
   // ----------------------------------------
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         holdCnt_r <= 32'h00000000;
         inReset_r <= 1'b1;
      end else if (clkEn && inReset_r) begin
         if (holdCnt_r >= RESET_HOLD_CYC - 1) begin
            inReset_r <= 1'b0;
         end else begin
            holdCnt_r <= holdCnt_r + 32'h00000001;
         end
      end
   end
   // ----------------------------------------
   // status and corrector
   // ----------------------------------------
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         lockOut               <= 1'b0;
         holdoverOut           <= 1'b0;
         ref_a_failure         <= 1'b0;
         ref_b_failure         <= 1'b0;
         ref_c_failure         <= 1'b0;
         lockOe_n              <= 1'b1;
         holdoverOe_n          <= 1'b1;
         refFailOe_n           <= 1'b1;
         opMode                <= `DPLLSC_MODE_NORMAL;
         prevMode_r            <= `DPLLSC_MODE_NORMAL;
         prevHold_r            <= 1'b0;
         phase_error_corrector <= {DLY_W{1'b0}};
         correctorLoad         <= 1'b0;
      end else if (clkEn) begin
         lockOe_n     <= inReset_r;
         holdoverOe_n <= inReset_r;
         refFailOe_n  <= inReset_r;
         correctorLoad <= 1'b0;
         if (!inReset_r) begin
            lockOut       <= freqLocked && !holdNow && !modeFree;
            holdoverOut   <= holdNow;
            ref_a_failure <= refFail[0];
            ref_b_failure <= refFail[1];
            ref_c_failure <= refFail[2];
            opMode        <= modeSel;
            prevMode_r    <= modeSel;
            prevHold_r    <= holdNow;
            if (returning && hitless_phase_select) begin
               phase_error_corrector <= measuredDelay;
               correctorLoad         <= 1'b1;
            end else if (returning) begin
               phase_error_corrector <= phase_error_corrector;
            end
         end
      end
   end
   // ----------------------------------------
   // test port sampling
   // ----------------------------------------
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         tckSync_r  <= 3'h0;
         tmsSync_r  <= 3'h7;
         tdiSync_r  <= 3'h7;
         tckLevel_r <= 1'b0;
         tmsLevel_r <= 1'b1;
         tdiLevel_r <= 1'b1;
      end else if (clkEn) begin
         tckSync_r <= {tckSync_r[1:0], testClk};
         tmsSync_r <= {tmsSync_r[1:0], testModeSel};
         tdiSync_r <= {tdiSync_r[1:0], testDataIn};
         if (tckSync_r[2] == tckSync_r[1]) begin
            tckLevel_r <= tckSync_r[1];
         end
         if (tmsSync_r[2] == tmsSync_r[1]) begin
            tmsLevel_r <= tmsSync_r[1];
         end
         if (tdiSync_r[2] == tdiSync_r[1]) begin
            tdiLevel_r <= tdiSync_r[1];
         end
      end
   end
   assign tckRise     = (tckSync_r[2] == tckSync_r[1]) && tckSync_r[1] && !tckLevel_r;
   assign tckFall     = (tckSync_r[2] == tckSync_r[1]) && !tckSync_r[1] && tckLevel_r;
   assign tapRstAsync = !testRst_n;
   // ----------------------------------------
   // test access port
   // ----------------------------------------
   dpllsc_tap #(
      .IR_W (4)
   ) uTap (
      .sys_clk     (sys_clk),
      .clkEn       (clkEn),
      .tapRstAsync (tapRstAsync),
      .tckRise     (tckRise),
      .tckFall     (tckFall),
      .tmsIn       (tmsLevel_r),
      .tdiIn       (tdiLevel_r),
      .tdoOut      (tdoRaw),
      .tdoOe_n     (tdoOeRaw)
   );
   assign testDataOut  = tdoRaw;
   assign testDataOe_n = tdoOeRaw || inReset_r;
endmodule

// file: design/dpllsc_defines.vh
`ifndef DPLLSC_DEFINES_VH
`define DPLLSC_DEFINES_VH
// ----------------------------------------
// timing
// ----------------------------------------
`define DPLLSC_CLK_PERIOD_NS 5
`define DPLLSC_RESET_HOLD_MS 3
`define DPLLSC_RESET_HOLD_CYC ((`DPLLSC_RESET_HOLD_MS * 1000000 + `DPLLSC_CLK_PERIOD_NS - 1) / `DPLLSC_CLK_PERIOD_NS)
// ----------------------------------------
// mode-select codes
// ----------------------------------------
`define DPLLSC_MODE_NORMAL   2'h0
`define DPLLSC_MODE_HOLDOVER 2'h1
`define DPLLSC_MODE_FREERUN  2'h2
`define DPLLSC_MODE_AUTO     2'h3
// ----------------------------------------
// tap states
// ----------------------------------------
`define DPLLSC_TAP_RESET  4'hF
`define DPLLSC_TAP_IDLE   4'hC
`define DPLLSC_TAP_SELDR  4'h7
`define DPLLSC_TAP_CAPDR  4'h6
`define DPLLSC_TAP_SHDR   4'h2
`define DPLLSC_TAP_EX1DR  4'h1
`define DPLLSC_TAP_PSDR   4'h3
`define DPLLSC_TAP_EX2DR  4'h0
`define DPLLSC_TAP_UPDR   4'h5
`define DPLLSC_TAP_SELIR  4'h4
`define DPLLSC_TAP_CAPIR  4'hE
`define DPLLSC_TAP_SHIR   4'hA
`define DPLLSC_TAP_EX1IR  4'h9
`define DPLLSC_TAP_PSIR   4'hB
`define DPLLSC_TAP_EX2IR  4'h8
`define DPLLSC_TAP_UPIR   4'hD
`define DPLLSC_IR_RESET   4'h1
`endif

// file: design/dpllsc_tap.v
`timescale 1ns/1ps
`include "dpllsc_defines.vh"
module dpllsc_tap #(
   parameter IR_W = 4
) (
   input  wire        sys_clk,
   input  wire        clkEn,
   input  wire        tapRstAsync,
   input  wire        tckRise,
   input  wire        tckFall,
   input  wire        tmsIn,
   input  wire        tdiIn,
   output reg         tdoOut,
   output reg         tdoOe_n
);
   reg  [3:0]      state_r;
   reg  [3:0]      state_nxt;
   reg  [IR_W-1:0] ir_r;
   reg             bypass_r;
   // ----------------------------------------
   // tap state walk
   // ----------------------------------------
   always @* begin
      state_nxt = state_r;
      case (state_r)
         `DPLLSC_TAP_RESET: state_nxt = tmsIn ? `DPLLSC_TAP_RESET : `DPLLSC_TAP_IDLE;
         `DPLLSC_TAP_IDLE:  state_nxt = tmsIn ? `DPLLSC_TAP_SELDR : `DPLLSC_TAP_IDLE;
         `DPLLSC_TAP_SELDR: state_nxt = tmsIn ? `DPLLSC_TAP_SELIR : `DPLLSC_TAP_CAPDR;
         `DPLLSC_TAP_CAPDR: state_nxt = tmsIn ? `DPLLSC_TAP_EX1DR : `DPLLSC_TAP_SHDR;
         `DPLLSC_TAP_SHDR:  state_nxt = tmsIn ? `DPLLSC_TAP_EX1DR : `DPLLSC_TAP_SHDR;
         `DPLLSC_TAP_EX1DR: state_nxt = tmsIn ? `DPLLSC_TAP_UPDR  : `DPLLSC_TAP_PSDR;
         `DPLLSC_TAP_PSDR:  state_nxt = tmsIn ? `DPLLSC_TAP_EX2DR : `DPLLSC_TAP_PSDR;
         `DPLLSC_TAP_EX2DR: state_nxt = tmsIn ? `DPLLSC_TAP_UPDR  : `DPLLSC_TAP_SHDR;
         `DPLLSC_TAP_UPDR:  state_nxt = tmsIn ? `DPLLSC_TAP_SELDR : `DPLLSC_TAP_IDLE;
         `DPLLSC_TAP_SELIR: state_nxt = tmsIn ? `DPLLSC_TAP_RESET : `DPLLSC_TAP_CAPIR;
         `DPLLSC_TAP_CAPIR: state_nxt = tmsIn ? `DPLLSC_TAP_EX1IR : `DPLLSC_TAP_SHIR;
         `DPLLSC_TAP_SHIR:  state_nxt = tmsIn ? `DPLLSC_TAP_EX1IR : `DPLLSC_TAP_SHIR;
         `DPLLSC_TAP_EX1IR: state_nxt = tmsIn ? `DPLLSC_TAP_UPIR  : `DPLLSC_TAP_PSIR;
         `DPLLSC_TAP_PSIR:  state_nxt = tmsIn ? `DPLLSC_TAP_EX2IR : `DPLLSC_TAP_PSIR;
         `DPLLSC_TAP_EX2IR: state_nxt = tmsIn ? `DPLLSC_TAP_UPIR  : `DPLLSC_TAP_SHIR;
         `DPLLSC_TAP_UPIR:  state_nxt = tmsIn ? `DPLLSC_TAP_SELDR : `DPLLSC_TAP_IDLE;
         default:           state_nxt = `DPLLSC_TAP_RESET;
      endcase
   end
   always @(posedge sys_clk or posedge tapRstAsync) begin
      if (tapRstAsync) begin
         state_r  <= `DPLLSC_TAP_RESET;
         ir_r     <= `DPLLSC_IR_RESET;
         bypass_r <= 1'b0;
      end else if (clkEn && tckRise) begin
         state_r <= state_nxt;
         if (state_r == `DPLLSC_TAP_RESET) begin
            ir_r <= `DPLLSC_IR_RESET;
         end else if (state_r == `DPLLSC_TAP_CAPIR) begin
            ir_r <= `DPLLSC_IR_RESET;
         end else if (state_r == `DPLLSC_TAP_SHIR) begin
            ir_r <= {tdiIn, ir_r[IR_W-1:1]};
         end
         if (state_r == `DPLLSC_TAP_CAPDR) begin
            bypass_r <= 1'b0;
         end else if (state_r == `DPLLSC_TAP_SHDR) begin
            bypass_r <= tdiIn;
         end
      end
   end
   // ----------------------------------------
   // output on falling test clock
   // ----------------------------------------
   always @(posedge sys_clk or posedge tapRstAsync) begin
      if (tapRstAsync) begin
         tdoOut  <= 1'b0;
         tdoOe_n <= 1'b1;
      end else if (clkEn && tckFall) begin
         tdoOut  <= (state_r == `DPLLSC_TAP_SHIR) ? ir_r[0] : bypass_r;
         tdoOe_n <= !((state_r == `DPLLSC_TAP_SHIR) || (state_r == `DPLLSC_TAP_SHDR));
      end
   end
endmodule

// file: dv/dpllsc_properties.sv
`timescale 1ns/1ps
module dpllsc_properties #(
   parameter RESET_HOLD_CYC = 20,
   parameter DLY_W          = 16
) (
   input wire             sys_clk,
   input wire             rst_n,
   input wire             op_mode_bit0,
   input wire             op_mode_bit1,
   input wire             hitless_phase_select,
   input wire             freqLocked,
   input wire             autoHoldover,
   input wire [2:0]       refOutOfRange,
   input wire [2:0]       refAbrupt,
   input wire [DLY_W-1:0] measuredDelay,
   input wire             testRst_n,
   input wire             lockOut,
   input wire             lockOe_n,
   input wire             holdoverOut,
   input wire             holdoverOe_n,
   input wire             ref_a_failure,
   input wire             ref_b_failure,
   input wire             ref_c_failure,
   input wire             refFailOe_n,
   input wire [1:0]       opMode,
   input wire [DLY_W-1:0] phase_error_corrector,
   input wire             correctorLoad,
   input wire             testDataOe_n
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   wire [1:0] modeIn = {op_mode_bit1, op_mode_bit0};
   reg [31:0] holdCnt_r;
   // ----------------------------------------
   // cycles since reset release
   // ----------------------------------------
   always @(posedge sys_clk) begin
      if (!rst_n)
         holdCnt_r <= 32'h0;
      else if (holdCnt_r < RESET_HOLD_CYC + 2)
         holdCnt_r <= holdCnt_r + 32'h1;
   end
   sequence settled;
      !lockOe_n && $past(!lockOe_n);
   endsequence
   sequence backToNormal;
      $fell(holdoverOut) && opMode != 2'h2;
   endsequence
   lock_follow_a: assert property (settled |->
      lockOut == ($past(freqLocked) && !holdoverOut && opMode != 2'h2))
      else $error("lock output wrong");
   holdover_follow_a: assert property (settled |->
      holdoverOut == (opMode == 2'h1 || (opMode == 2'h3 && $past(autoHoldover))))
      else $error("holdover output wrong");
   ref_fail_a: assert property (settled |->
      {ref_c_failure, ref_b_failure, ref_a_failure} == $past(refOutOfRange | refAbrupt))
      else $error("reference failure wrong");
   mode_decode_a: assert property (settled |-> opMode == $past(modeIn))
      else $error("mode decode wrong");
   scan_release_a: assert property (!testRst_n |-> testDataOe_n)
      else $error("scan output driven in test reset");
   hold_release_a: assert property (lockOe_n |->
      holdoverOe_n && refFailOe_n && testDataOe_n && !lockOut && !holdoverOut)
      else $error("output driven in reset hold");
   hold_length_a: assert property (holdCnt_r < RESET_HOLD_CYC + 1 |-> lockOe_n)
      else $error("reset hold too short");
   hold_end_a: assert property (holdCnt_r >= RESET_HOLD_CYC + 1 |-> !lockOe_n)
      else $error("reset hold too long");
   fresh_delay_a: assert property (backToNormal ##0 $past(hitless_phase_select) |->
      correctorLoad && phase_error_corrector == $past(measuredDelay))
      else $error("corrector not re-measured");
   keep_delay_a: assert property (backToNormal ##0 !$past(hitless_phase_select) |-> !correctorLoad)
      else $error("corrector reloaded");
   delay_stable_a: assert property ($changed(phase_error_corrector) |-> correctorLoad)
      else $error("corrector changed without load");
endmodule
bind dpll_status_control_pins dpllsc_properties #(.RESET_HOLD_CYC(RESET_HOLD_CYC), .DLY_W(DLY_W)) u_dpllsc_properties (
   .sys_clk(sys_clk), .rst_n(rst_n), .op_mode_bit0(op_mode_bit0), .op_mode_bit1(op_mode_bit1),
   .hitless_phase_select(hitless_phase_select), .freqLocked(freqLocked), .autoHoldover(autoHoldover),
   .refOutOfRange(refOutOfRange), .refAbrupt(refAbrupt), .measuredDelay(measuredDelay), .testRst_n(testRst_n),
   .lockOut(lockOut), .lockOe_n(lockOe_n), .holdoverOut(holdoverOut), .holdoverOe_n(holdoverOe_n),
   .ref_a_failure(ref_a_failure), .ref_b_failure(ref_b_failure), .ref_c_failure(ref_c_failure),
   .refFailOe_n(refFailOe_n), .opMode(opMode), .phase_error_corrector(phase_error_corrector),
   .correctorLoad(correctorLoad), .testDataOe_n(testDataOe_n));

// file: dv/dpllsc_host_model.sv
`timescale 1ns/1ps
module dpllsc_host_model (
   output reg testClk,
   output reg testModeSel,
   output reg testDataIn,
   output reg testRst_n
);
   initial begin
      testClk = 1'b0;
      testModeSel = 1'b1;
      testDataIn = 1'b1;
      testRst_n = 1'b0;
      #100;
      testRst_n = 1'b1;
   end
   task pulseReset;
      begin
         testRst_n = 1'b0;
         #100;
         testRst_n = 1'b1;
      end
   endtask
   task step(input tms, input tdi);
      begin
         testModeSel = tms;
         testDataIn = tdi;
         #62.5 testClk = 1'b1;
         #62.5 testClk = 1'b0;
      end
   endtask
endmodule

// file: dv/test_dpll_status_control_pins.sv
`timescale 1ns/1ps
module test_dpll_status_control_pins;
   reg        sys_clk, rst_n, clkEn, op_mode_bit0, op_mode_bit1, hitless_phase_select, freqLocked, autoHoldover;
   reg [1:0]  application_select;
   reg [2:0]  refOutOfRange, refAbrupt;
   reg [15:0] measuredDelay;
   wire       testClk, testModeSel, testDataIn, testRst_n, lockOut, lockOe_n, holdoverOut, holdoverOe_n;
   wire       ref_a_failure, ref_b_failure, ref_c_failure, refFailOe_n, correctorLoad, testDataOut, testDataOe_n;
   wire [1:0] opMode;
   wire [15:0] phase_error_corrector;
   integer    mismatches, testsRun;
   dpll_status_control_pins #(.RESET_HOLD_CYC(20), .DLY_W(16)) u_dpll_status_control_pins (
      .sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn), .op_mode_bit0(op_mode_bit0), .op_mode_bit1(op_mode_bit1),
      .hitless_phase_select(hitless_phase_select), .application_select(application_select), .freqLocked(freqLocked),
      .autoHoldover(autoHoldover), .refOutOfRange(refOutOfRange), .refAbrupt(refAbrupt), .measuredDelay(measuredDelay),
      .testClk(testClk), .testModeSel(testModeSel), .testDataIn(testDataIn), .testRst_n(testRst_n), .lockOut(lockOut),
      .lockOe_n(lockOe_n), .holdoverOut(holdoverOut), .holdoverOe_n(holdoverOe_n), .ref_a_failure(ref_a_failure),
      .ref_b_failure(ref_b_failure), .ref_c_failure(ref_c_failure), .refFailOe_n(refFailOe_n), .opMode(opMode),
      .phase_error_corrector(phase_error_corrector), .correctorLoad(correctorLoad), .testDataOut(testDataOut),
      .testDataOe_n(testDataOe_n));
   dpllsc_host_model u_dpllsc_host_model (
      .testClk(testClk), .testModeSel(testModeSel), .testDataIn(testDataIn), .testRst_n(testRst_n));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task check(input [15:0] seen, input [15:0] exp);
      begin
         testsRun = testsRun + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task cyc(input integer n);
      begin
         repeat (n) @(posedge sys_clk);
         #1;
      end
   endtask
   task setMode(input [1:0] m);
      begin
         op_mode_bit1 = m[1];
         op_mode_bit0 = m[0];
      end
   endtask
   task stopTest;
      begin
         $display("checks %0d, mismatches %0d", testsRun, mismatches);
         if (mismatches == 0 && testsRun > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_hold;
      begin
         cyc(3);
         rst_n = 1'b1;
         cyc(18);
         check({lockOe_n, holdoverOe_n, refFailOe_n, lockOut}, 4'hE);
         cyc(6);
         check({lockOe_n, holdoverOe_n, refFailOe_n, lockOut}, 4'h1);
         $display("reset hold test done");
      end
   endtask
   task t_status;
      integer m, i;
      begin
         for (m = 0; m < 4; m = m + 1) begin
            setMode(m[1:0]);
            cyc(2);
            check({opMode, holdoverOut, lockOut}, {m[1:0], m == 1 || m == 3, m == 0});
         end
         autoHoldover = 1'b0;
         freqLocked = 1'b0;
         cyc(2);
         check({holdoverOut, lockOut}, 2'h0);
         for (i = 0; i < 3; i = i + 1) begin
            application_select = i[1:0];
            refOutOfRange = 3'h1 << i;
            refAbrupt = 3'h6 >> i;
            cyc(2);
            check({ref_c_failure, ref_b_failure, ref_a_failure}, (3'h1 << i) | (3'h6 >> i));
         end
         $display("status test done");
      end
   endtask
   task t_hitless;
      integer h;
      reg [15:0] want;
      begin
         for (h = 0; h < 4; h = h + 1) begin
            setMode(h < 2 ? 2'h1 : 2'h2);
            cyc(3);
            measuredDelay = 16'hA5C3 + h[15:0];
            hitless_phase_select = h[0];
            setMode(2'h0);
            cyc(1);
            check(correctorLoad, h[0]);
            cyc(2);
            want = h[0] ? 16'hA5C3 + h[15:0] : (h < 2 ? 16'h0000 : 16'hA5C4);
            check(phase_error_corrector, want);
         end
         $display("hitless test done");
      end
   endtask
   task t_tap;
      begin
         u_dpllsc_host_model.pulseReset;
         #20;
         check(testDataOe_n, 1'b1);
         u_dpllsc_host_model.step(1'b0, 1'b0);
         u_dpllsc_host_model.step(1'b1, 1'b0);
         u_dpllsc_host_model.step(1'b0, 1'b0);
         u_dpllsc_host_model.step(1'b0, 1'b1);
         #30;
         check({testDataOe_n, testDataOut}, 2'h0);
         u_dpllsc_host_model.step(1'b0, 1'b1);
         #30;
         check({testDataOe_n, testDataOut}, 2'h1);
         u_dpllsc_host_model.pulseReset;
         #20;
         check(testDataOe_n, 1'b1);
         $display("scan test done");
      end
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   initial begin
      #100000;
      mismatches = mismatches + 1;
      stopTest;
   end
   initial begin
      mismatches = 0;
      testsRun = 0;
      {rst_n, clkEn, hitless_phase_select, freqLocked, autoHoldover} = 5'h0F;
      setMode(2'h0);
      application_select = 2'h0;
      {refOutOfRange, refAbrupt} = 6'h00;
      measuredDelay = 16'h0000;
      t_hold;
      t_status;
      t_hitless;
      t_tap;
      stopTest;
   end
endmodule
